// ==== verilog/mtr_pkg.sv ====
// Constants and types for the transmit threshold and run control block.
// Assumes a 32-bit register port with byte offsets on an 8-bit address.
package mtr_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFF_MODE = 8'h18;
    localparam logic [7:0] OFF_DESC = 8'h20;
    localparam logic [7:0] OFF_STAT = 8'h24;

    // ==========================================================
    // Operating mode fields
    localparam int TTH_LSB = 14;
    localparam int TTH_W = 7;
    localparam int RUN_BIT = 13;
    localparam int RSV_BIT = 12;
    localparam int LBK_LSB = 10;
    localparam int LBK_W = 2;
    localparam int THR_SHIFT = 4;
    localparam logic [31:0] MODE_RST = 32'h0000_0000;
    localparam logic [31:0] DESC_RST = 32'h0000_0000;

    // ==========================================================
    // Status fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_FULL_BIT = 2;
    localparam int STAT_CNT_LSB = 16;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_FILL = 2'b10,
        ST_SEND = 2'b11
    } mtr_state_t;

    typedef enum logic [1:0]
    {
        LB_NORMAL = 2'b00,
        LB_INTERNAL = 2'b01,
        LB_EXTERNAL = 2'b10
    } mtr_loop_t;
endpackage

// ==== verilog/mtr_tx_control.sv ====
// Transmit start threshold, transmit run control and loopback select.
// Assumes the DMA, FIFO and MAC share clk and give one-cycle pulses.
//
// Notes on behaviour
// [R1] Bits 20:14 hold the threshold; a frame starts once its queued bytes reach it.
// [R2] A frame also starts as soon as it is wholly queued, even below the threshold.
// [R3] Software changes the threshold only while the transmit machine is idle.
// [R4] Threshold zero waits for the full frame; value n means n times sixteen bytes.
// [R5] Setting the run bit 13 leaves idle and first fetches the descriptor at the pointer.
// [R6] Clearing the run bit stops the machine only once the current frame has ended.
// [R7] Software loads the descriptor pointer before it sets the run bit.
// [R8] Bit 12 is reserved and always reads as zero.
// [R9] Bits 11:10 select normal, internal loopback or external loopback.
// [R10] The byte count covers only the head frame and restarts for each frame.
`timescale 1ns/1ps
module mtr_tx_control #(
    parameter int CNT_W = 11,
    parameter int IN_W = 3
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    output logic descFetchReq,
    output logic [31:0] descFetchAddr,
    input wire logic descFetchAck,
    input wire logic [IN_W-1:0] fifoBytesIn,
    input wire logic fifoFrameQueued,
    output logic txStart,
    input wire logic txDone,
    input wire logic txAbortColl,
    output logic [1:0] loopbackMode,
    output logic txIdle
);
    // ==========================================================
    // Parameter checks
    // The counter must hold the largest threshold of 2032 bytes.
    if (CNT_W < 11 || CNT_W > 16)
    begin : g_bad_cnt
        $error("CNT_W must lie between 11 and 16");
    end
    if (IN_W < 1 || IN_W > 4)
    begin : g_bad_in
        $error("IN_W must lie between 1 and 4");
    end

    function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
        regHit = (a == off);
    endfunction

    // ==========================================================
    // Registers and state
    logic [mtr_pkg::TTH_W-1:0] txStartThreshold_q, txStartThreshold_d;
    logic txRun_q, txRun_d;
    logic [1:0] loopbackSelect_q, loopbackSelect_d;
    logic [31:0] currentTxDescriptorPointer_q, currentTxDescriptorPointer_d;
    mtr_pkg::mtr_state_t state_q, state_d;
    logic [CNT_W-1:0] byteCnt_q, byteCnt_d;
    logic full_q, full_d;
    logic [31:0] rdData_q, rdData_d;
    logic fetchReq_q, fetchReq_d;
    logic start_q, start_d;
    logic [1:0] loop_q, loop_d;
    logic idle_q, idle_d;
    logic [CNT_W-1:0] thrBytes;
    logic thrReached;

    assign thrBytes = CNT_W'(txStartThreshold_q) << mtr_pkg::THR_SHIFT; // [R4]
    assign thrReached = (txStartThreshold_q != '0) && (byteCnt_q >= thrBytes); // [R1] [R4]

    always_comb
    begin
        txStartThreshold_d = txStartThreshold_q;
        txRun_d = txRun_q;
        loopbackSelect_d = loopbackSelect_q;
        currentTxDescriptorPointer_d = currentTxDescriptorPointer_q;
        rdData_d = 32'h0000_0000;
        if (regWr && regHit(regAddr, mtr_pkg::OFF_MODE))
        begin
            txStartThreshold_d = regWrData[mtr_pkg::TTH_LSB +: mtr_pkg::TTH_W]; // [R1]
            txRun_d = regWrData[mtr_pkg::RUN_BIT];
            loopbackSelect_d = regWrData[mtr_pkg::LBK_LSB +: mtr_pkg::LBK_W]; // [R9]
        end
        else if (regWr && regHit(regAddr, mtr_pkg::OFF_DESC))
        begin
            currentTxDescriptorPointer_d = regWrData;
        end
        if (regRd && regHit(regAddr, mtr_pkg::OFF_MODE))
        begin
            // Bit 12 and all other unheld bits stay zero.
            rdData_d[mtr_pkg::TTH_LSB +: mtr_pkg::TTH_W] = txStartThreshold_q;
            rdData_d[mtr_pkg::RUN_BIT] = txRun_q;
            rdData_d[mtr_pkg::RSV_BIT] = 1'b0; // [R8]
            rdData_d[mtr_pkg::LBK_LSB +: mtr_pkg::LBK_W] = loopbackSelect_q;
        end
        else if (regRd && regHit(regAddr, mtr_pkg::OFF_DESC))
        begin
            rdData_d = currentTxDescriptorPointer_q;
        end
        else if (regRd && regHit(regAddr, mtr_pkg::OFF_STAT))
        begin
            rdData_d[mtr_pkg::STAT_STATE_LSB +: 2] = state_q;
            rdData_d[mtr_pkg::STAT_FULL_BIT] = full_q;
            rdData_d[mtr_pkg::STAT_CNT_LSB +: CNT_W] = byteCnt_q;
        end
    end

    // ==========================================================
    // Transmit state machine
    always_comb
    begin
        state_d = state_q;
        byteCnt_d = byteCnt_q;
        full_d = full_q;
        fetchReq_d = 1'b0;
        start_d = 1'b0;
        case (state_q)
            mtr_pkg::ST_IDLE:
            begin
                if (txRun_q)
                begin
                    state_d = mtr_pkg::ST_FETCH; // [R5]
                    fetchReq_d = 1'b1;
                end
            end
            mtr_pkg::ST_FETCH:
            begin
                fetchReq_d = 1'b1;
                if (descFetchAck)
                begin
                    fetchReq_d = 1'b0;
                    // No frame has begun yet, so a cleared run bit stops here.
                    state_d = txRun_q ? mtr_pkg::ST_FILL : mtr_pkg::ST_IDLE; // [R6]
                    byteCnt_d = '0; // [R10]
                    full_d = 1'b0;
                end
            end
            mtr_pkg::ST_FILL:
            begin
                byteCnt_d = byteCnt_q + CNT_W'(fifoBytesIn); // [R10]
                full_d = full_q | fifoFrameQueued;
                if (full_q || thrReached)
                begin
                    state_d = mtr_pkg::ST_SEND; // [R1] [R2]
                    start_d = 1'b1;
                end
            end
            mtr_pkg::ST_SEND:
            begin
                if (txDone || txAbortColl)
                begin
                    state_d = txRun_q ? mtr_pkg::ST_FETCH : mtr_pkg::ST_IDLE; // [R6]
                    fetchReq_d = txRun_q;
                end
            end
            default:
            begin
                state_d = mtr_pkg::ST_IDLE;
            end
        endcase
        loop_d = (loopbackSelect_q == 2'h3) ? mtr_pkg::LB_NORMAL : loopbackSelect_q; // [R9]
        idle_d = (state_d == mtr_pkg::ST_IDLE);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            txStartThreshold_q <= mtr_pkg::MODE_RST[mtr_pkg::TTH_LSB +: mtr_pkg::TTH_W];
            txRun_q <= mtr_pkg::MODE_RST[mtr_pkg::RUN_BIT];
            loopbackSelect_q <= mtr_pkg::MODE_RST[mtr_pkg::LBK_LSB +: mtr_pkg::LBK_W];
            currentTxDescriptorPointer_q <= mtr_pkg::DESC_RST;
            state_q <= mtr_pkg::ST_IDLE;
            byteCnt_q <= '0;
            full_q <= 1'b0;
            rdData_q <= 32'h0000_0000;
            fetchReq_q <= 1'b0;
            start_q <= 1'b0;
            loop_q <= mtr_pkg::LB_NORMAL;
            idle_q <= 1'b1;
        end
        else
        begin
            txStartThreshold_q <= txStartThreshold_d;
            txRun_q <= txRun_d;
            loopbackSelect_q <= loopbackSelect_d;
            currentTxDescriptorPointer_q <= currentTxDescriptorPointer_d;
            state_q <= state_d;
            byteCnt_q <= byteCnt_d;
            full_q <= full_d;
            rdData_q <= rdData_d;
            fetchReq_q <= fetchReq_d;
            start_q <= start_d;
            loop_q <= loop_d;
            idle_q <= idle_d;
        end
    end

    assign regRdData = rdData_q;
    assign descFetchReq = fetchReq_q;
    assign descFetchAddr = currentTxDescriptorPointer_q;
    assign txStart = start_q;
    assign loopbackMode = loop_q;
    assign txIdle = idle_q;

    // ==========================================================
    // Checks
    a_thresh_start: assert property (@(posedge clk) disable iff (rst) // [R1]
        state_q == mtr_pkg::ST_FILL && thrReached |=> txStart && state_q == mtr_pkg::ST_SEND)
        else $error("threshold reached without a start");
    a_full_start: assert property (@(posedge clk) disable iff (rst) // [R2]
        state_q == mtr_pkg::ST_FILL && full_q |=> txStart)
        else $error("queued frame did not start");
    a_zero_waits: assert property (@(posedge clk) disable iff (rst) // [R4]
        state_q == mtr_pkg::ST_FILL && txStartThreshold_q == '0 && !full_q |=> !txStart)
        else $error("zero threshold started before full frame");
    a_run_fetch: assert property (@(posedge clk) disable iff (rst) // [R5]
        state_q == mtr_pkg::ST_IDLE && txRun_q
        |=> descFetchReq && descFetchAddr == $past(currentTxDescriptorPointer_q))
        else $error("run bit did not fetch descriptor");
    a_stop_after_frame: assert property (@(posedge clk) disable iff (rst) // [R6]
        state_q == mtr_pkg::ST_SEND && !(txDone || txAbortColl) |=> state_q == mtr_pkg::ST_SEND)
        else $error("frame left before completion");
    a_rsv_zero: assert property (@(posedge clk) disable iff (rst) // [R8]
        regRd && regAddr == mtr_pkg::OFF_MODE |=> regRdData[mtr_pkg::RSV_BIT] == 1'b0)
        else $error("reserved bit read nonzero");
    a_loop_select: assert property (@(posedge clk) disable iff (rst) // [R9]
        regWr && regAddr == mtr_pkg::OFF_MODE && regWrData[11:10] != 2'h3
        |=> ##1 loopbackMode == $past(regWrData[11:10], 2))
        else $error("loopback mode not applied");
    a_count_restart: assert property (@(posedge clk) disable iff (rst) // [R10]
        state_q == mtr_pkg::ST_FETCH && descFetchAck && txRun_q |=> byteCnt_q == '0 && !full_q)
        else $error("byte count not restarted");
endmodule

// ==== tb/mtr_far_side.sv ====
// Far-side model: descriptor fetch, FIFO fill and MAC send for the transmit control.
// Assumes one clock shared with the block and its synchronous reset.
`timescale 1ns/1ps
module mtr_far_side
(
    input wire logic clk,
    input wire logic rst,
    input wire logic descFetchReq,
    output logic descFetchAck,
    output logic [2:0] fifoBytesIn,
    output logic fifoFrameQueued,
    input wire logic txStart,
    output logic txDone,
    output logic txAbortColl,
    input wire logic [11:0] frameLen,
    input wire logic [2:0] ackDelay,
    input wire logic abortNext,
    output logic [11:0] startFed
);
    // ==========================================================
    // Fetch, fill and send
    logic [11:0] fed;
    logic [11:0] left;
    logic [2:0] ackCnt;
    logic [3:0] sendCnt;
    logic feeding;
    logic acked;
    assign left = frameLen - fed;
    // Each frame is held ten cycles on the wire, so run can be cleared mid-frame.
    always_ff @(posedge clk)
    begin
        fifoFrameQueued <= 1'b0;
        fifoBytesIn <= 3'h0;
        txDone <= 1'b0;
        txAbortColl <= 1'b0;
        ackCnt <= (descFetchReq && !acked) ? ackCnt + 3'h1 : 3'h0;
        acked <= descFetchReq && (acked || ackCnt == ackDelay);
        descFetchAck <= descFetchReq && !acked && ackCnt == ackDelay;
        if (descFetchAck)
        begin
            feeding <= 1'b1;
            fed <= 12'h0;
        end
        else if (feeding)
        begin
            fifoBytesIn <= (left > 12'h4) ? 3'h4 : left[2:0];
            fed <= fed + ((left > 12'h4) ? 12'h4 : left);
            fifoFrameQueued <= left <= 12'h4;
            feeding <= left > 12'h4;
        end
        if (txStart)
        begin
            startFed <= fed;
            sendCnt <= 4'ha;
        end
        else if (sendCnt != 4'h0)
        begin
            sendCnt <= sendCnt - 4'h1;
            txDone <= sendCnt == 4'h1 && !abortNext;
            txAbortColl <= sendCnt == 4'h1 && abortNext;
        end
        if (rst)
        begin
            {feeding, acked, ackCnt, sendCnt} <= '0;
            {fed, startFed, descFetchAck} <= '0;
        end
    end
endmodule

// ==== tb/mac_tx_threshold_and_run_control_test.sv ====
// Self-checking bench for the transmit threshold and run control block.
// Assumes the far-side model sends each frame for ten cycles.
`timescale 1ns/1ps
module mac_tx_threshold_and_run_control_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdData, descFetchAddr;
    logic descFetchReq, descFetchAck, fifoFrameQueued, txStart, txDone, txAbortColl, txIdle;
    logic [2:0] fifoBytesIn;
    logic [1:0] loopbackMode;
    logic [11:0] frameLen = 12'h0, startFed;
    logic [2:0] ackDelay = 3'h0;
    logic abortNext = 1'b0;
    int mismatches = 0;
    int comparisons = 0;
    always #2.5 clk = ~clk;
    mtr_tx_control dut (.clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
        .descFetchReq, .descFetchAddr, .descFetchAck, .fifoBytesIn, .fifoFrameQueued,
        .txStart, .txDone, .txAbortColl, .loopbackMode, .txIdle);
    mtr_far_side far (.clk, .rst, .descFetchReq, .descFetchAck, .fifoBytesIn,
        .fifoFrameQueued, .txStart, .txDone, .txAbortColl, .frameLen, .ackDelay,
        .abortNext, .startFed);
    // ==========================================================
    // Shared tasks
    task automatic stop_test();
        if (mismatches == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 check(regRdData, exp);
    endtask
    // Waits for fetch request, start pulse or idle; a start or idle timeout shows in the caller's check.
    task automatic await(input int which);
        for (int i = 0; i < 2000; i++)
        begin
            @(posedge clk);
            #1;
            if (which == 0 ? descFetchReq : which == 1 ? txStart : txIdle)
                break;
        end
    endtask
    // ==========================================================
    // Scenarios
    task automatic test_regs();
        rd(mtr_pkg::OFF_MODE, mtr_pkg::MODE_RST);
        rd(mtr_pkg::OFF_DESC, mtr_pkg::DESC_RST);
        check({31'h0, txIdle}, 32'h1);
        wr(mtr_pkg::OFF_MODE, 32'hffff_dfff);
        rd(mtr_pkg::OFF_MODE, 32'h001f_cc00);
        check({30'h0, loopbackMode}, 32'h0);
        for (int m = 0; m < 3; m++)
        begin
            wr(mtr_pkg::OFF_MODE, 32'(m) << mtr_pkg::LBK_LSB);
            repeat (2) @(posedge clk);
            #1 check({30'h0, loopbackMode}, 32'(m));
        end
        rd(8'h04, 32'h0);
    endtask
    task automatic test_frames(input logic [6:0] thr, input logic [11:0] len,
        input logic [2:0] dly, input logic abrt);
        logic [11:0] lo;
        logic [11:0] hi;
        logic [11:0] cnt;
        lo = (thr == 7'h0 || 12'({thr, 4'h0}) >= len) ? len : 12'({thr, 4'h0});
        hi = (lo == len) ? len : lo + 12'h8;
        @(posedge clk);
        frameLen <= len;
        ackDelay <= dly;
        abortNext <= abrt;
        wr(mtr_pkg::OFF_DESC, 32'h0001_2340);
        wr(mtr_pkg::OFF_MODE, (32'(thr) << mtr_pkg::TTH_LSB) | 32'h2000);
        await(0);
        check(descFetchAddr, 32'h0001_2340);
        for (int f = 0; f < 2; f++)
        begin
            await(1);
            check({31'h0, txStart}, 32'h1);
            @(posedge clk);
            #1 check(32'(startFed >= lo && startFed <= hi), 32'h1);
        end
        wr(mtr_pkg::OFF_MODE, 32'(thr) << mtr_pkg::TTH_LSB);
        #1 check({31'h0, txIdle}, 32'h0);
        await(2);
        check({31'h0, txIdle}, 32'h1);
        check({31'h0, descFetchReq}, 32'h0);
        // The count holds the last frame only; a threshold start sees one more 4-byte beat.
        cnt = (lo == len) ? len : lo + 12'h4;
        rd(mtr_pkg::OFF_STAT, (32'(cnt) << mtr_pkg::STAT_CNT_LSB) | ((lo == len) ? 32'h4 : 32'h0));
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        test_regs();
        test_frames(7'h01, 12'h064, 3'h0, 1'b0);
        test_frames(7'h00, 12'h028, 3'h5, 1'b1);
        test_frames(7'h7f, 12'h800, 3'h2, 1'b0);
        test_frames(7'h7f, 12'h03c, 3'h1, 1'b1);
        test_frames(7'h02, 12'h064, 3'h7, 1'b0);
        stop_test();
    end
    // The tests need about 1400 cycles; the limit leaves a wide margin.
    initial
    begin
        #100000;
        mismatches++;
        stop_test();
    end
endmodule
